// >>> hw/lmi_pkg.sv
package lmi_pkg;

  // System clock period in nanoseconds (25 MHz).
  localparam int CLK_NS = 40;

  // Bus timing figures in nanoseconds, fast mode then fast mode plus.
  localparam int T_PER_FM_NS    = 2500;
  localparam int T_PER_FMP_NS   = 1000;
  localparam int T_HIGH_FM_NS   = 700;
  localparam int T_HIGH_FMP_NS  = 260;
  localparam int T_LOW_FM_NS    = 1300;
  localparam int T_LOW_FMP_NS   = 500;
  localparam int T_HD_STA_FM_NS = 600;
  localparam int T_HD_STA_FMP_NS = 260;
  localparam int T_SU_STA_FM_NS = 600;
  localparam int T_SU_STA_FMP_NS = 260;
  localparam int T_SU_STO_FM_NS = 600;
  localparam int T_SU_STO_FMP_NS = 260;
  localparam int T_BUF_FM_NS    = 1300;
  localparam int T_BUF_FMP_NS   = 500;

  localparam int CNT_W = 8;

  // Least times round up to whole cycles and never fall below one.
  function automatic logic [CNT_W-1:0] lmi_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1) begin
      c = 1;
    end
    return CNT_W'(c);
  endfunction : lmi_cyc

  // Low phase is stretched so the whole period meets the rate ceiling.
  function automatic int lmi_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : lmi_max

  localparam logic [CNT_W-1:0] C_HIGH_FM   = lmi_cyc(T_HIGH_FM_NS);
  localparam logic [CNT_W-1:0] C_HIGH_FMP  = lmi_cyc(T_HIGH_FMP_NS);
  localparam logic [CNT_W-1:0] C_LOW_FM    =
    lmi_cyc(lmi_max(T_LOW_FM_NS, T_PER_FM_NS - T_HIGH_FM_NS));
  localparam logic [CNT_W-1:0] C_LOW_FMP   =
    lmi_cyc(lmi_max(T_LOW_FMP_NS, T_PER_FMP_NS - T_HIGH_FMP_NS));
  localparam logic [CNT_W-1:0] C_HD_STA_FM  = lmi_cyc(T_HD_STA_FM_NS);
  localparam logic [CNT_W-1:0] C_HD_STA_FMP = lmi_cyc(T_HD_STA_FMP_NS);
  localparam logic [CNT_W-1:0] C_SU_STA_FM  = lmi_cyc(T_SU_STA_FM_NS);
  localparam logic [CNT_W-1:0] C_SU_STA_FMP = lmi_cyc(T_SU_STA_FMP_NS);
  localparam logic [CNT_W-1:0] C_SU_STO_FM  = lmi_cyc(T_SU_STO_FM_NS);
  localparam logic [CNT_W-1:0] C_SU_STO_FMP = lmi_cyc(T_SU_STO_FMP_NS);
  localparam logic [CNT_W-1:0] C_BUF_FM     = lmi_cyc(T_BUF_FM_NS);
  localparam logic [CNT_W-1:0] C_BUF_FMP    = lmi_cyc(T_BUF_FMP_NS);

  // Field layout of the address byte.
  localparam int DIR_POS  = 0;
  localparam int PIN_LSB  = 1;
  localparam int FIX_LSB  = 3;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ  = 1'h1;
  localparam int ACK_SLOT = 8;

  // Where the device's address-select pin is tied.
  typedef enum logic [1:0] {
    STRAP_GND = 2'h0,
    STRAP_VCC = 2'h1,
    STRAP_SCL = 2'h2,
    STRAP_SDA = 2'h3
  } lmi_strap_t;

  typedef struct packed {
    logic       rw;        // 1 = read, 0 = write
    logic       fast_plus; // 1 = 1 MHz timing, 0 = 400 kHz timing
    lmi_strap_t strap;     // device address-select tie
    logic [7:0] reg_addr;  // first register
    logic [7:0] len_m1;    // data bytes minus one
  } lmi_cmd_t;

  typedef struct packed {
    logic       scl;     // serial clock level driven
    logic       sda_o;   // data output level (always low)
    logic       sda_oe;  // data line pulled low while high
  } lmi_pins_t;

endpackage : lmi_pkg

// >>> hw/lmi_host.sv
`timescale 1ns/10ps
// How it works
// - First byte after start: seven address bits above, direction bit lowest.
// - Direction bit zero means write, one means read.
// - Sample data while clock high; hold sent bits steady while clock high.
// - Data line stays released high while the bus is idle.
// - Start is data falling while clock high; address follows.
// - Master sends the address byte as eight bits, MSB first, after start.
// - After eight bits master releases data and gives an acknowledge pulse.
// - No low acknowledge: master sends stop and abandons the transfer.
// - Register address byte follows, MSB first, and is acknowledged.
// - Each data byte is eight bits MSB first, each acknowledged except the last read byte.
// - Stop is data rising while clock high; it ends the transfer.
// - Read: write register address, repeated start, then direction one.
module lmi_host
  import lmi_pkg::*;
#(
  parameter logic [4:0] FIXED_CODE = 5'h15,  // arbitrary part code
  parameter int         DW         = 8       // read buffer word width
) (
  input  wire logic          clk,         // system clock, 25 MHz
  input  wire logic          rst,         // synchronous reset, high
  input  wire logic          ce,          // clock enable, freezes all state
  input  wire lmi_cmd_t      cmd,         // transfer request
  input  wire logic          cmd_valid,   // request present
  output logic               cmd_ready,   // request may be taken
  input  wire logic [7:0]    wr_data,     // write byte
  input  wire logic          wr_valid,    // write byte present
  output logic               wr_ready,    // write byte may be taken
  output logic [DW-1:0]      rd_data,     // read byte
  output logic               rd_valid,    // read byte present
  input  wire logic          rd_ready,    // consumer takes read byte
  output logic               done,        // transfer finished, pulse
  output logic               nack,        // with done: device refused
  output logic               busy,        // transfer in progress
  output logic               scl,         // serial clock out
  output logic               sda_o,       // serial data level when driven
  output logic               sda_oe,      // serial data driven low
  input  wire logic          sda_i        // serial data line level
);

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_START   = 4'h1,
    ST_LOW     = 4'h2,
    ST_HIGH    = 4'h3,
    ST_NEXT    = 4'h4,
    ST_WAIT_WR = 4'h5,
    ST_WAIT_RD = 4'h6,
    ST_STOP_LO = 4'h7,
    ST_STOP_HI = 4'h8,
    ST_BUF     = 4'h9,
    ST_RS_LO   = 4'ha,
    ST_RS_HI   = 4'hb
  } lmi_state_t;

  typedef enum logic [2:0] {
    K_ADDR_W = 3'h0,
    K_REG    = 3'h1,
    K_DATA_W = 3'h2,
    K_ADDR_R = 3'h3,
    K_DATA_R = 3'h4
  } lmi_kind_t;

  function automatic logic [1:0] pin_bits(input lmi_strap_t s);
    unique case (s)
      STRAP_GND: pin_bits = 2'h0;
      STRAP_VCC: pin_bits = 2'h3;
      STRAP_SCL: pin_bits = 2'h1;
      STRAP_SDA: pin_bits = 2'h2;
    endcase
  endfunction : pin_bits

  function automatic logic [7:0] addr_byte(input lmi_strap_t s,
                                           input logic dir);
    logic [7:0] b;
    b = 8'h00;
    b[7:FIX_LSB] = FIXED_CODE;
    b[FIX_LSB-1:PIN_LSB] = pin_bits(s);
    b[DIR_POS] = dir;
    return b;
  endfunction : addr_byte

  lmi_state_t       state_r;
  lmi_kind_t        kind_r;
  lmi_cmd_t         cmd_r;
  logic [CNT_W-1:0] cnt_r;
  logic [3:0]       bit_r;
  logic [7:0]       shift_r;
  logic [7:0]       remain_r;
  logic             ack_seen_r;
  logic             sda_s1_r;
  logic             sda_s2_r;
  logic             sda_s3_r;
  logic             sda_in_r;
  logic             spare_v_r;
  logic [DW-1:0]    spare_r;
  logic             push;
  logic             pop;
  lmi_pins_t        pins_r;

  ////////////////////////////////////////////////////////////////////////////
  // Data line input: three stages, a change counts once stages two and three
  // agree, which keeps a slow edge from being read as two values.

  always_ff @(posedge clk) begin
    if (rst) begin
      sda_s1_r <= 1'h1;
      sda_s2_r <= 1'h1;
      sda_s3_r <= 1'h1;
      sda_in_r <= 1'h1;
    end else if (ce) begin
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
      if (sda_s2_r == sda_s3_r) begin
        sda_in_r <= sda_s3_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase timing, chosen per transfer.

  function automatic logic [CNT_W-1:0] tsel(input logic fp,
                                            input logic [CNT_W-1:0] a,
                                            input logic [CNT_W-1:0] b);
    return fp ? b : a;
  endfunction : tsel

  logic [CNT_W-1:0] c_low;
  logic [CNT_W-1:0] c_high;
  logic [CNT_W-1:0] c_hd_sta;
  logic [CNT_W-1:0] c_su_sta;
  logic [CNT_W-1:0] c_su_sto;
  logic [CNT_W-1:0] c_buf;

  assign c_low    = tsel(cmd_r.fast_plus, C_LOW_FM, C_LOW_FMP);
  assign c_high   = tsel(cmd_r.fast_plus, C_HIGH_FM, C_HIGH_FMP);
  assign c_hd_sta = tsel(cmd_r.fast_plus, C_HD_STA_FM, C_HD_STA_FMP);
  assign c_su_sta = tsel(cmd_r.fast_plus, C_SU_STA_FM, C_SU_STA_FMP);
  assign c_su_sto = tsel(cmd_r.fast_plus, C_SU_STO_FM, C_SU_STO_FMP);
  assign c_buf    = tsel(cmd_r.fast_plus, C_BUF_FM, C_BUF_FMP);

  ////////////////////////////////////////////////////////////////////////////
  // Bus sequencer. The serial clock is divided down from clk here, so the
  // link needs no second clock domain at this end.

  assign push = ce && (state_r == ST_NEXT) && (kind_r == K_DATA_R);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      kind_r     <= K_ADDR_W;
      cmd_r      <= '0;
      cnt_r      <= '0;
      bit_r      <= 4'h0;
      shift_r    <= 8'h00;
      remain_r   <= 8'h00;
      ack_seen_r <= 1'h0;
      pins_r     <= '{scl: 1'h1, sda_o: 1'h0, sda_oe: 1'h0};
      cmd_ready  <= 1'h0;
      wr_ready   <= 1'h0;
      done       <= 1'h0;
      nack       <= 1'h0;
      busy       <= 1'h0;
    end else if (ce) begin
      done     <= 1'h0;
      wr_ready <= 1'h0;
      if (cnt_r != '0) begin
        cnt_r <= cnt_r - CNT_W'(1);
      end
      unique case (state_r)
        ST_IDLE: begin
          pins_r.scl    <= 1'h1;
          pins_r.sda_oe <= 1'h0;
          cmd_ready     <= 1'h1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready     <= 1'h0;
            busy          <= 1'h1;
            nack          <= 1'h0;
            cmd_r         <= cmd;
            remain_r      <= cmd.len_m1;
            shift_r       <= addr_byte(cmd.strap, DIR_WRITE);
            kind_r        <= K_ADDR_W;
            pins_r.sda_oe <= 1'h1;
            cnt_r         <= cmd.fast_plus ? C_HD_STA_FMP : C_HD_STA_FM;
            state_r       <= ST_START;
          end
        end
        ST_START: begin
          if (cnt_r == '0) begin
            pins_r.scl <= 1'h0;
            bit_r      <= 4'h0;
            cnt_r      <= c_low;
            state_r    <= ST_LOW;
          end
        end
        ST_LOW: begin
          // Data changes at least one cycle after the clock falls, giving hold time.
          if (cnt_r == c_low) begin
            if (bit_r < 4'(ACK_SLOT)) begin
              pins_r.sda_oe <= (kind_r != K_DATA_R) && !shift_r[7];
            end else if (kind_r == K_DATA_R) begin
              pins_r.sda_oe <= (remain_r != 8'h00);
            end else begin
              pins_r.sda_oe <= 1'h0;
            end
          end
          if (cnt_r == '0) begin
            pins_r.scl <= 1'h1;
            cnt_r      <= c_high;
            state_r    <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (cnt_r == '0) begin
            pins_r.scl <= 1'h0;
            cnt_r      <= c_low;
            if (bit_r < 4'(ACK_SLOT)) begin
              shift_r <= {shift_r[6:0], sda_in_r};
              bit_r   <= bit_r + 4'h1;
              state_r <= ST_LOW;
            end else begin
              ack_seen_r <= !sda_in_r;
              state_r    <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          cnt_r <= c_low;
          if (kind_r != K_DATA_R && !ack_seen_r) begin
            nack          <= 1'h1;
            pins_r.sda_oe <= 1'h1;
            state_r       <= ST_STOP_LO;
          end else begin
            unique case (kind_r)
              K_ADDR_W: begin
                shift_r <= cmd_r.reg_addr;
                kind_r  <= K_REG;
                bit_r   <= 4'h0;
                state_r <= ST_LOW;
              end
              K_REG: begin
                if (cmd_r.rw == DIR_READ) begin
                  pins_r.sda_oe <= 1'h0;
                  state_r       <= ST_RS_LO;
                end else begin
                  wr_ready <= 1'h1;
                  state_r  <= ST_WAIT_WR;
                end
              end
              K_DATA_W: begin
                remain_r <= remain_r - 8'h01;
                if (remain_r == 8'h00) begin
                  pins_r.sda_oe <= 1'h1;
                  state_r       <= ST_STOP_LO;
                end else begin
                  wr_ready <= 1'h1;
                  state_r  <= ST_WAIT_WR;
                end
              end
              K_ADDR_R: begin
                state_r <= ST_WAIT_RD;
              end
              K_DATA_R: begin
                remain_r <= remain_r - 8'h01;
                if (remain_r == 8'h00) begin
                  pins_r.sda_oe <= 1'h1;
                  state_r       <= ST_STOP_LO;
                end else begin
                  state_r <= ST_WAIT_RD;
                end
              end
              default: begin
                state_r <= ST_STOP_LO;
              end
            endcase
          end
        end
        ST_WAIT_WR: begin
          // The clock stays low while the source has nothing to send.
          wr_ready <= !(wr_valid && wr_ready);
          if (wr_valid && wr_ready) begin
            wr_ready <= 1'h0;
            shift_r  <= wr_data;
            kind_r   <= K_DATA_W;
            bit_r    <= 4'h0;
            cnt_r    <= c_low;
            state_r  <= ST_LOW;
          end
        end
        ST_WAIT_RD: begin
          // A full buffer holds the clock low, so no read byte is lost.
          if (!spare_v_r) begin
            kind_r  <= K_DATA_R;
            bit_r   <= 4'h0;
            cnt_r   <= c_low;
            state_r <= ST_LOW;
          end
        end
        ST_RS_LO: begin
          if (cnt_r == '0) begin
            pins_r.scl <= 1'h1;
            cnt_r      <= c_su_sta;
            state_r    <= ST_RS_HI;
          end
        end
        ST_RS_HI: begin
          if (cnt_r == '0) begin
            pins_r.sda_oe <= 1'h1;
            shift_r       <= addr_byte(cmd_r.strap, DIR_READ);
            kind_r        <= K_ADDR_R;
            cnt_r         <= c_hd_sta;
            state_r       <= ST_START;
          end
        end
        ST_STOP_LO: begin
          pins_r.sda_oe <= 1'h1;
          if (cnt_r == '0) begin
            pins_r.scl <= 1'h1;
            cnt_r      <= c_su_sto;
            state_r    <= ST_STOP_HI;
          end
        end
        ST_STOP_HI: begin
          if (cnt_r == '0) begin
            pins_r.sda_oe <= 1'h0;
            cnt_r         <= c_buf;
            state_r       <= ST_BUF;
          end
        end
        ST_BUF: begin
          if (cnt_r == '0) begin
            done    <= 1'h1;
            busy    <= 1'h0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign scl    = pins_r.scl;
  assign sda_o  = pins_r.sda_o;
  assign sda_oe = pins_r.sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry read buffer: an output register and one spare. Outputs come
  // straight from flops at the cost of a slightly wider mux on push.

  assign pop = ce && rd_valid && rd_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid  <= 1'h0;
      rd_data   <= '0;
      spare_v_r <= 1'h0;
      spare_r   <= '0;
    end else if (ce) begin
      if (!rd_valid) begin
        if (push) begin
          rd_data  <= DW'(shift_r);
          rd_valid <= 1'h1;
        end
      end else if (pop) begin
        if (spare_v_r) begin
          rd_data   <= spare_r;
          spare_v_r <= push;
          if (push) begin
            spare_r <= DW'(shift_r);
          end
        end else if (push) begin
          rd_data <= DW'(shift_r);
        end else begin
          rd_valid <= 1'h0;
        end
      end else if (push) begin
        spare_r   <= DW'(shift_r);
        spare_v_r <= 1'h1;
      end
    end
  end

endmodule : lmi_host

// >>> sim/lmi_host_asserts.sv
`timescale 1ns/10ps
module lmi_host_asserts
  import lmi_pkg::*;
#(
  parameter int DW = 8  // read word width
) (
  input wire logic          clk,        // system clock
  input wire logic          rst,        // sync reset
  input wire logic          ce,         // clock enable
  input wire logic          cmd_valid,  // request present
  input wire logic          cmd_ready,  // request may be taken
  input wire logic          wr_valid,   // write byte present
  input wire logic          wr_ready,   // write byte wanted
  input wire logic [DW-1:0] rd_data,    // read byte
  input wire logic          rd_valid,   // read byte present
  input wire logic          rd_ready,   // read byte popped
  input wire logic          done,       // end pulse
  input wire logic          busy,       // in transfer
  input wire logic          scl,        // serial clock
  input wire logic          sda_o,      // data level
  input wire logic          sda_oe      // data pulled low
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_drive_low_only: assert property (sda_oe |-> !sda_o)
    else $error("data line driven high");
  a_idle_free: assert property (cmd_ready |-> scl && !sda_oe)
    else $error("bus not released while idle");
  a_start_first: assert property (cmd_valid && cmd_ready && ce
    |-> ##[1:2] (scl && sda_oe))
    else $error("no start after accept");
  a_accept_busy: assert property (cmd_valid && cmd_ready && ce
    |=> busy && !cmd_ready)
    else $error("accept did not raise busy");
  a_high_min: assert property ($rose(scl) |=> scl [*6])
    else $error("clock high phase too short");
  a_low_min: assert property ($fell(scl) |=> !scl [*8])
    else $error("clock low phase too short");
  // The data line holds steady for five cycles after the clock rises; start and stop setup times are longer than that.
  a_hold_high: assert property ($rose(scl) |=> $stable(sda_oe)[*5])
    else $error("data moved while clock high");
  a_done_stop: assert property (done |-> scl && !sda_oe ##1 !done)
    else $error("done without stop");
  a_wr_wait_low: assert property (wr_ready && !scl |=> !scl)
    else $error("clock ran while waiting for data");
  a_wr_take: assert property (wr_valid && wr_ready |=> !wr_ready)
    else $error("write byte taken twice");
  a_rd_hold: assert property (rd_valid && !rd_ready
    |=> rd_valid && $stable(rd_data))
    else $error("read byte lost while stalled");
endmodule : lmi_host_asserts

bind lmi_host lmi_host_asserts #(.DW(DW)) u_asserts (
  .clk(clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
  .done(done), .busy(busy), .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe)
);

// >>> sim/lmi_dev_model.sv
`timescale 1ns/10ps
module lmi_dev_model
  import lmi_pkg::*;
#(
  parameter logic [4:0] FIXED_CODE = 5'h15  // arbitrary part code
) (
  input wire logic       scl,   // serial clock from host
  input wire logic       sda,   // resolved data line
  input wire lmi_strap_t tie,   // where the select pin is tied
  output logic           pull   // device pulls data low
);
  logic [7:0] mem [256];
  logic [7:0] sh, tx, ptr, last_addr;
  logic [1:0] pin;
  logic       ls = 1'b1;
  int         st = 0;
  int         cnt = 0;

  initial pull = 1'b0;

  always_comb begin
    case (tie)
      STRAP_GND: pin = 2'h0;
      STRAP_VCC: pin = 2'h3;
      STRAP_SCL: pin = 2'h1;
      default:   pin = 2'h2;
    endcase
  end

  task automatic take_byte();
    case (st)
      1: begin
        last_addr = sh;
        if (sh[7:1] == {FIXED_CODE, pin}) begin
          pull = 1'b1;
          st = sh[0] ? 4 : 2;
        end else begin
          st = 0;
        end
      end
      2: begin
        ptr = sh;
        pull = 1'b1;
        st = 3;
      end
      default: begin
        mem[ptr] = sh;
        ptr++;
        pull = 1'b1;
      end
    endcase
  endtask : take_byte

  task automatic fall_edge();
    if (st == 0) return;
    if (cnt < 0) cnt = 0;
    else if (cnt < 7) begin
      cnt++;
      if (st == 4) pull = !tx[7-cnt];
    end else if (cnt == 7) begin
      cnt = 8;
      if (st == 4) pull = 1'b0;
      else take_byte();
    end else begin
      cnt = 0;
      pull = 1'b0;
      if (st == 4) begin
        tx = mem[ptr];
        ptr++;
        pull = !tx[7];
      end
    end
  endtask : fall_edge

  // One process sees both lines, so edges of the two never race.
  always @(scl or sda) begin
    if (scl === 1'b1 && ls === 1'b0) begin
      if (st == 4 && cnt == 8 && sda !== 1'b0) st = 0;
      else if (st != 0 && st != 4 && cnt >= 0 && cnt < 8)
        sh = {sh[6:0], sda};
    end else if (scl === 1'b0 && ls === 1'b1) begin
      fall_edge();
    end else if (scl === 1'b1) begin
      pull = 1'b0;
      st = (sda === 1'b0) ? 1 : 0;
      cnt = -1;
    end
    ls = scl;
  end
endmodule : lmi_dev_model

// >>> sim/lmi_host_tb.sv
`timescale 1ns/10ps
module lmi_host_tb
  import lmi_pkg::*;
;
  localparam logic [4:0] FIX = 5'h15;  // arbitrary part code
  localparam logic [1:0] PINS [4] = '{2'h0, 2'h3, 2'h1, 2'h2};

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_valid = 1'b0;
  logic       wr_valid = 1'b0;
  logic       rd_ready = 1'b0;
  logic       pulled = 1'b0;
  logic [7:0] wr_data = 8'h00;
  lmi_cmd_t   cmd = '0;
  lmi_strap_t tie = STRAP_GND;
  logic       cmd_ready, wr_ready, rd_valid, done, nack, busy;
  logic       scl, sda_o, sda_oe, pull;
  logic [7:0] rd_data;
  logic [7:0] wb [8];
  logic [7:0] rb [8];
  wire        sda;
  int         errors = 0, n_tests = 0, cyc = 0, nrd, nwr;

  // The pull-up makes a released line read high.
  assign sda = sda_oe ? sda_o : (pull ? 1'b0 : 1'b1);

  lmi_host #(.FIXED_CODE(FIX), .DW(8)) DUT (
    .clk(clk), .rst(rst), .ce(1'b1), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .done(done), .nack(nack), .busy(busy),
    .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe), .sda_i(sda)
  );
  lmi_dev_model #(.FIXED_CODE(FIX)) u_dev (
    .scl(scl), .sda(sda), .tie(tie), .pull(pull)
  );

  always #20 clk = ~clk;
  always @(posedge pull) pulled = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] dv(input int s, input int i);
    return 8'(8'hA5 + 8'h11 * s + i);
  endfunction : dv

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // Only the first stall cycles hold back both the writer and the reader.
  task automatic xfer(input lmi_cmd_t c, input int stall);
    int   k;
    int   w;
    logic tw;
    w = 0;
    nrd = 0;
    k = 0;
    @(posedge clk);
    cmd <= c;
    cmd_valid <= 1'b1;
    do @(negedge clk); while (cmd_ready !== 1'b1 && ++k < 100);
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    chk("busy in transfer", 8'h1, {7'h0, busy});
    for (k = 0; k < 20000; k++) begin
      @(negedge clk);
      if (done === 1'b1) break;
      tw = (wr_valid & wr_ready) === 1'b1;
      if ((rd_valid & rd_ready) === 1'b1) begin
        rb[nrd % 8] = rd_data;
        nrd++;
      end
      @(posedge clk);
      if (tw) w++;
      wr_data <= wb[w % 8];
      wr_valid <= (k >= stall);
      rd_ready <= (k >= stall);
    end
    @(posedge clk);
    wr_valid <= 1'b0;
    rd_ready <= 1'b0;
    nwr = w;
    chk("transfer ended", 8'h1, {7'h0, k < 20000});
    chk("busy after done", 8'h0, {7'h0, busy});
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    repeat (12) @(posedge clk);
    chk("idle clock", 8'h1, {7'h0, scl});
    chk("idle data drive", 8'h0, {7'h0, sda_oe});
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("ready after reset", 8'h1, {7'h0, cmd_ready});
    $display("test reset done");
  endtask : t_reset

  task automatic t_write();
    lmi_cmd_t c;
    for (int s = 0; s < 4; s++) begin
      tie = lmi_strap_t'(s);
      for (int i = 0; i < 8; i++) wb[i] = dv(s, i);
      c = '{1'b0, s[0], lmi_strap_t'(s), {s[1:0], 6'h3E}, 8'h02};
      xfer(c, (s == 2) ? 1300 : 0);
      chk("write nack", 8'h0, {7'h0, nack});
      chk("bytes taken", 8'h3, 8'(nwr));
      chk("address byte", {FIX, PINS[s], 1'b0}, u_dev.last_addr);
      for (int i = 0; i < 3; i++) begin
        chk("register", dv(s, i), u_dev.mem[8'(c.reg_addr + i)]);
      end
    end
    $display("test write done");
  endtask : t_write

  task automatic t_read();
    lmi_cmd_t c;
    tie = STRAP_VCC;
    c = '{1'b1, 1'b1, STRAP_VCC, 8'h7E, 8'h02};
    xfer(c, 3000);
    chk("read nack", 8'h0, {7'h0, nack});
    chk("read count", 8'h3, 8'(nrd));
    for (int i = 0; i < 3; i++) chk("read byte", dv(1, i), rb[i]);
    chk("read address", {FIX, 2'h3, 1'b1}, u_dev.last_addr);
    $display("test read done");
  endtask : t_read

  task automatic t_miss();
    lmi_cmd_t c;
    tie = STRAP_GND;
    pulled = 1'b0;
    c = '{1'b0, 1'b1, STRAP_SDA, 8'h20, 8'h00};
    xfer(c, 0);
    chk("refused nack", 8'h1, {7'h0, nack});
    chk("refused bytes", 8'h0, 8'(nwr));
    chk("device silent", 8'h0, {7'h0, pulled});
    $display("test mismatch done");
  endtask : t_miss

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    t_reset();
    t_write();
    t_read();
    t_miss();
    finish_test();
  end
endmodule : lmi_host_tb
